/* File: core/flag_polarity_irq.sv */
// flag pin polarity, start level selection and external interrupt aggregation
// What this block does
// - pin flag passes when its polarity bit is 0, inverted when 1.
// - polarity register holds flags 0..12, resets to zero, acts on pin-routed flags and on start inputs not used as flags.
// - start input not used as flag: polarity 0 active high, 1 active low.
// - any requesting source drives the interrupt output low.
// - cause register captures all sources when the interrupt output asserts.
// - while interrupt output is asserted the cause register holds.
// - no source requesting releases the output high and clears causes.
// - cause bits 0..3 report diagnosis stops of the four core channels.
// - cause bits 4..7 report microcode requests of the four core channels.
// - cause bit 8 reports drivers disabled by driver status logic.
// - cause bit 9 reports a serial communication error.
// - cause bit 10 reports loss of the system clock.
// - cause bits 11 and 12 report code checksum failure of channels 1, 2.
// - microcore requests arrive already gated by their own configuration.
// - flag with source bit 0 keeps pin function; bus takes internal flag unchanged.
// - input flag pin drives the bus; output flag internal flag drives the pin.
`timescale 1ns/1ps
`default_nettype none
`include "flag_irq_consts.svh"
module flag_polarity_irq #(
    parameter int NPF = `NUM_PIN_FLAGS,
    parameter int NF  = `NUM_FLAGS
) (
    // clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   rstn,
    // register port from the serial interface
    input  wire logic [`REG_ADDR_W-1:0] reg_addr,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    input  wire logic [`REG_DATA_W-1:0] reg_wdata,
    output logic      [`REG_DATA_W-1:0] reg_rdata,
    // flag routing configuration and flag signals
    input  wire logic [NPF-1:0]         flag_source,
    input  wire logic [NPF-1:0]         flag_direction,
    input  wire logic [NF-1:0]          int_flags,
    output logic      [NF-1:0]          flag_bus,
    // device pins sharing the flag bus
    input  wire logic [NPF-1:0]         pin_in,
    output logic      [NPF-1:0]         pin_out,
    output logic      [NPF-1:0]         pin_oe,
    // start levels when start pins are not flags
    output logic      [`NUM_START-1:0]  trigger_active,
    // interrupt sources, already enabled upstream
    input  wire logic [3:0]             diag_stop,
    input  wire logic [3:0]             core_request,
    input  wire logic                   drv_off_req,
    input  wire logic                   spi_err_req,
    input  wire logic                   clk_loss_req,
    input  wire logic                   code_sum_fail_chan1,
    input  wire logic                   code_sum_fail_chan2,
    // interrupt toward the controller
    output logic                        host_interrupt_out_n
);
    logic [NPF-1:0]              flag_pin_inversion;
    logic [`NUM_IRQ_SRC-1:0]     interrupt_cause_latch;
    logic [NPF-1:0]              pin_clean;
    logic [`NUM_IRQ_SRC-1:0]     src;
    logic                        any_req;
    flag_irq_pkg::irq_state_t    irq_state;

    flag_glitch_filter #(
        .WIDTH  (NPF),
        .CYCLES (`FILTER_CYCLES)
    ) u_filter (
        .core_clk (core_clk),
        .rstn     (rstn),
        .raw      (pin_in),
        .clean    (pin_clean)
    );

    // register writes; only 13 bits exist, the top three read back zero
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            flag_pin_inversion <= `FLAG_PIN_INV_RESET;
        end else if (reg_wr && reg_addr == `OFS_FLAG_PIN_INV) begin
            flag_pin_inversion <= reg_wdata[NPF-1:0];
        end
    end

    // read data valid the cycle after the read strobe; unmapped reads zero
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `OFS_FLAG_PIN_INV: reg_rdata <= {{(`REG_DATA_W-NPF){1'b0}}, flag_pin_inversion};
                `OFS_IRQ_CAUSE:    reg_rdata <= {{(`REG_DATA_W-`NUM_IRQ_SRC){1'b0}}, interrupt_cause_latch};
                default:           reg_rdata <= '0;
            endcase
        end
    end

    // flag bus and pins; top flags are internal only
    genvar i;
    generate
        for (i = 0; i < NPF; i++) begin : g_flag
            always_ff @(posedge core_clk or negedge rstn) begin
                if (!rstn) begin
                    flag_bus[i] <= 1'b0;
                    pin_out[i]  <= 1'b0;
                    pin_oe[i]   <= 1'b0;
                end else if (!flag_source[i]) begin
                    flag_bus[i] <= int_flags[i];
                    // the interrupt pin keeps its own function when not a flag
                    pin_out[i]  <= (i == `IRQ_PIN_FLAG) ? ~any_req : 1'b0;
                    pin_oe[i]   <= (i == `IRQ_PIN_FLAG);
                end else if (flag_direction[i]) begin
                    flag_bus[i] <= pin_clean[i] ^ flag_pin_inversion[i];
                    pin_out[i]  <= 1'b0;
                    pin_oe[i]   <= 1'b0;
                end else begin
                    flag_bus[i] <= int_flags[i];
                    pin_out[i]  <= int_flags[i] ^ flag_pin_inversion[i];
                    pin_oe[i]   <= 1'b1;
                end
            end
        end
        for (i = NPF; i < NF; i++) begin : g_int
            always_ff @(posedge core_clk or negedge rstn) begin
                if (!rstn) begin
                    flag_bus[i] <= 1'b0;
                end else begin
                    flag_bus[i] <= int_flags[i];
                end
            end
        end
        for (i = 0; i < `NUM_START; i++) begin : g_start
            always_ff @(posedge core_clk or negedge rstn) begin
                if (!rstn) begin
                    trigger_active[i] <= 1'b0;
                end else begin
                    // 1 selects an active-low start input
                    trigger_active[i] <= !flag_source[`START_FIRST_FLAG+i]
                        && (pin_clean[`START_FIRST_FLAG+i] ^ flag_pin_inversion[`START_FIRST_FLAG+i]);
                end
            end
        end
    endgenerate

    // source vector in cause-bit order
    assign src = {code_sum_fail_chan2, code_sum_fail_chan1,
                  clk_loss_req,
                  spi_err_req,
                  drv_off_req,
                  core_request,
                  diag_stop};
    assign any_req = |src;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            irq_state             <= flag_irq_pkg::IRQ_IDLE;
            host_interrupt_out_n  <= 1'b1;
            interrupt_cause_latch <= `IRQ_CAUSE_RESET;
        end else begin
            unique case (irq_state)
                flag_irq_pkg::IRQ_IDLE: begin
                    if (any_req) begin
                        irq_state             <= flag_irq_pkg::IRQ_HELD;
                        host_interrupt_out_n  <= 1'b0;
                        interrupt_cause_latch <= src;
                    end
                end
                flag_irq_pkg::IRQ_HELD: begin
                    // causes frozen so software sees the first snapshot
                    if (!any_req) begin
                        irq_state             <= flag_irq_pkg::IRQ_IDLE;
                        host_interrupt_out_n  <= 1'b1;
                        interrupt_cause_latch <= `IRQ_CAUSE_RESET;
                    end
                end
            endcase
        end
    end

    property p_assert_low;
        @(posedge core_clk) disable iff (!rstn) any_req |=> !host_interrupt_out_n;
    endproperty
    a_assert_low: assert property (p_assert_low) else $error("irq not low after request");

    property p_snapshot;
        @(posedge core_clk) disable iff (!rstn)
            (host_interrupt_out_n && any_req) |=> (interrupt_cause_latch == $past(src));
    endproperty
    a_snapshot: assert property (p_snapshot) else $error("cause not captured at assert");

    property p_hold;
        @(posedge core_clk) disable iff (!rstn)
            (!host_interrupt_out_n && any_req) |=> $stable(interrupt_cause_latch);
    endproperty
    a_hold: assert property (p_hold) else $error("cause changed while asserted");

    property p_release;
        @(posedge core_clk) disable iff (!rstn)
            !any_req |=> (host_interrupt_out_n && interrupt_cause_latch == '0);
    endproperty
    a_release: assert property (p_release) else $error("irq not released and cleared");

    property p_cause_subset;
        @(posedge core_clk) disable iff (!rstn)
            host_interrupt_out_n |-> (interrupt_cause_latch == '0);
    endproperty
    a_cause_subset: assert property (p_cause_subset) else $error("cause set while idle");

    property p_out_flag;
        @(posedge core_clk) disable iff (!rstn)
            (flag_source[0] && !flag_direction[0]) |=> (pin_oe[0] && pin_out[0] == ($past(int_flags[0]) ^ $past(flag_pin_inversion[0])));
    endproperty
    a_out_flag: assert property (p_out_flag) else $error("output flag polarity wrong");

    property p_in_flag;
        @(posedge core_clk) disable iff (!rstn)
            (flag_source[1] && flag_direction[1]) |=> (!pin_oe[1] && flag_bus[1] == ($past(pin_clean[1]) ^ $past(flag_pin_inversion[1])));
    endproperty
    a_in_flag: assert property (p_in_flag) else $error("input flag polarity wrong");

    property p_no_flag;
        @(posedge core_clk) disable iff (!rstn)
            !flag_source[4] |=> (flag_bus[4] == $past(int_flags[4]) && !pin_oe[4]);
    endproperty
    a_no_flag: assert property (p_no_flag) else $error("unrouted flag not from internal bus");

    property p_start;
        @(posedge core_clk) disable iff (!rstn)
            !flag_source[3] |=> (trigger_active[0] == ($past(pin_clean[3]) ^ $past(flag_pin_inversion[3])));
    endproperty
    a_start: assert property (p_start) else $error("start level wrong");

    property p_diag_bit;
        @(posedge core_clk) disable iff (!rstn)
            (host_interrupt_out_n && diag_stop[2]) |=> interrupt_cause_latch[`CAUSE_DIAG_LSB+2];
    endproperty
    a_diag_bit: assert property (p_diag_bit) else $error("diag cause bit missing");

    property p_sum_bit;
        @(posedge core_clk) disable iff (!rstn)
            (host_interrupt_out_n && code_sum_fail_chan2) |=> interrupt_cause_latch[`CAUSE_SUM_CHAN2];
    endproperty
    a_sum_bit: assert property (p_sum_bit) else $error("checksum cause bit missing");

    c_assert: cover property (@(posedge core_clk) disable iff (!rstn) $fell(host_interrupt_out_n));
    c_late_src: cover property (@(posedge core_clk) disable iff (!rstn)
        !host_interrupt_out_n && $rose(spi_err_req));
    c_release: cover property (@(posedge core_clk) disable iff (!rstn) $rose(host_interrupt_out_n));
    c_inv_in: cover property (@(posedge core_clk) disable iff (!rstn)
        flag_source[1] && flag_direction[1] && flag_pin_inversion[1]);
endmodule
`default_nettype wire

/* File: include/flag_irq_consts.svh */
// offsets, field positions, reset values and timing counts for the flag/irq block
`ifndef FLAG_IRQ_CONSTS_SVH
`define FLAG_IRQ_CONSTS_SVH

`define REG_ADDR_W           10
`define REG_DATA_W           16
`define OFS_FLAG_PIN_INV     10'h1c2
`define OFS_IRQ_CAUSE        10'h1d4
`define FLAG_PIN_INV_RESET   13'h0000
`define IRQ_CAUSE_RESET      13'h0000

`define NUM_PIN_FLAGS        13
`define NUM_FLAGS            16
`define NUM_IRQ_SRC          13
`define NUM_START            6
`define START_FIRST_FLAG     3
`define IRQ_PIN_FLAG         9

`define CAUSE_DIAG_LSB       0
`define CAUSE_CORE_REQ_LSB   4
`define CAUSE_DRV_OFF        8
`define CAUSE_SPI_ERR        9
`define CAUSE_CLK_LOSS       10
`define CAUSE_SUM_CHAN1      11
`define CAUSE_SUM_CHAN2      12

`define FILTER_CYCLES        3

`endif

/* File: include/flag_irq_pkg.sv */
// types for the flag polarity and interrupt aggregator
package flag_irq_pkg;
    typedef enum logic [0:0] {
        IRQ_IDLE = 1'b0,
        IRQ_HELD = 1'b1
    } irq_state_t;
endpackage

/* File: core/flag_glitch_filter.sv */
// per-bit anti-glitch filter: output follows input once stable for a set number of cycles
`timescale 1ns/1ps
`default_nettype none
module flag_glitch_filter #(
    parameter int WIDTH  = 13,
    parameter int CYCLES = 3
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             rstn,
    // raw and filtered levels
    input  wire logic [WIDTH-1:0] raw,
    output logic      [WIDTH-1:0] clean
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic [CYCLES-1:0] hist;
            always_ff @(posedge core_clk or negedge rstn) begin
                if (!rstn) begin
                    hist <= '0;
                end else begin
                    hist <= {hist[CYCLES-2:0], raw[i]};
                end
            end
            // a pulse shorter than the window never reaches the flag bus
            always_ff @(posedge core_clk or negedge rstn) begin
                if (!rstn) begin
                    clean[i] <= 1'b0;
                end else if (&hist) begin
                    clean[i] <= 1'b1;
                end else if (~|hist) begin
                    clean[i] <= 1'b0;
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

/* File: verification/flag_pin_world.sv */
// far-side pin world: resolves each shared pin from the device drive or the outside level
`timescale 1ns/1ps
`default_nettype none
module flag_pin_world (
    // device side of the pins
    input  wire logic [12:0] pin_out,
    input  wire logic [12:0] pin_oe,
    // level forced by outside parts where the device does not drive
    input  wire logic [12:0] ext_level,
    // resolved pin level back to the device
    output logic      [12:0] pin_in
);
    // device drive wins; the outside part never fights an enabled pin
    always_comb begin
        for (int i = 0; i < 13; i++) begin
            pin_in[i] = pin_oe[i] ? pin_out[i] : ext_level[i];
        end
    end
endmodule
`default_nettype wire

/* File: verification/tb_flag_polarity_irq.sv */
// self-checking bench for the flag polarity and interrupt aggregator
`timescale 1ns/1ps
`default_nettype none
`include "flag_irq_consts.svh"
module tb_flag_polarity_irq;
    typedef struct {int kind; logic [15:0] exp; int due;} note_t;
    logic        core_clk = 1'b0;
    logic        rstn = 1'b0;
    logic [9:0]  reg_addr = 10'h000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] int_flags = 16'h0000;
    logic [12:0] flag_source = 13'h0000;
    logic [12:0] flag_direction = 13'h0000;
    logic [12:0] ext_level = 13'h0000;
    logic [12:0] irq_src = 13'h0000;
    logic [15:0] reg_rdata;
    logic [15:0] flag_bus;
    logic [12:0] pin_in;
    logic [12:0] pin_out;
    logic [12:0] pin_oe;
    logic [5:0]  trigger_active;
    logic        host_interrupt_out_n;
    logic [12:0] p;
    logic [12:0] x;
    logic [15:0] r;
    note_t       notes[$];
    note_t       cur;
    int          cyc = 0;
    int          seed = 92619;
    int          rv;
    int          miscompares = 0;
    int          total_checks = 0;

    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) cyc <= cyc + 1;

    flag_polarity_irq dut (
        .core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .flag_source(flag_source),
        .flag_direction(flag_direction), .int_flags(int_flags), .flag_bus(flag_bus), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .trigger_active(trigger_active), .diag_stop(irq_src[3:0]),
        .core_request(irq_src[7:4]), .drv_off_req(irq_src[8]), .spi_err_req(irq_src[9]),
        .clk_loss_req(irq_src[10]), .code_sum_fail_chan1(irq_src[11]), .code_sum_fail_chan2(irq_src[12]),
        .host_interrupt_out_n(host_interrupt_out_n));
    flag_pin_world world (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level), .pin_in(pin_in));

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic cmp(input string name, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask

    // one compare per kind of result, all sharing the same mismatch report
    task automatic cmp_rdata(input logic [15:0] exp, input logic [15:0] got);
        cmp("reg_rdata", exp, got);
    endtask

    task automatic cmp_flag_bus(input logic [15:0] exp, input logic [15:0] got);
        cmp("flag_bus", exp, got);
    endtask

    task automatic cmp_pin_out(input logic [15:0] exp, input logic [12:0] got);
        cmp("pin_out", exp, {3'h0, got});
    endtask

    task automatic cmp_pin_oe(input logic [15:0] exp, input logic [12:0] got);
        cmp("pin_oe", exp, {3'h0, got});
    endtask

    task automatic cmp_irq(input logic [15:0] exp, input logic got);
        cmp("host_interrupt_out_n", exp, {15'h0000, got});
    endtask

    task automatic cmp_trigger(input logic [15:0] exp, input logic [5:0] got);
        cmp("trigger_active", exp, {10'h000, got});
    endtask

    // lat counts edges after the current one; the watcher looks at the falling edge after that
    task automatic note(input int kind, input logic [15:0] exp, input int lat);
        notes.push_back(note_t'{kind, exp, cyc + 1 + lat});
    endtask

    task automatic wr(input logic [9:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [9:0] a, input logic [15:0] exp);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        note(0, exp, 1);
        @(posedge core_clk);
        reg_rd <= 1'b0;
    endtask

    always @(negedge core_clk) begin
        while (notes.size() > 0 && notes[0].due <= cyc) begin
            cur = notes.pop_front();
            case (cur.kind)
                0: cmp_rdata(cur.exp, reg_rdata);
                1: cmp_flag_bus(cur.exp, flag_bus);
                2: cmp_pin_out(cur.exp, pin_out);
                3: cmp_pin_oe(cur.exp, pin_oe);
                4: cmp_irq(cur.exp, host_interrupt_out_n);
                default: cmp_trigger(cur.exp, trigger_active);
            endcase
        end
    end

    initial begin
        #500000;
        miscompares++;
        give_verdict();
    end

    initial begin
        repeat (12) @(posedge core_clk);
        rstn <= 1'b1;
        note(4, 16'h0001, 0);
        rd(10'h1c2, 16'h0000);
        rd(10'h1d4, 16'h0000);
        rv = $random(seed);
        p = rv[12:0];
        wr(10'h1c2, rv[15:0]);
        rd(10'h1c2, {3'h0, p});
        wr(10'h1d4, 16'hffff);
        rd(10'h1d4, 16'h0000);
        rd(10'h3ff, 16'h0000);
        $display("test registers done");
        rv = $random(seed);
        r = rv[15:0];
        @(posedge core_clk);
        flag_source <= 13'h1fff;
        int_flags <= r;
        repeat (3) @(posedge core_clk);
        note(2, {3'h0, r[12:0] ^ p}, 0);
        note(3, 16'h1fff, 0);
        note(1, r, 0);
        note(5, 16'h0000, 0);
        $display("test output flags done");
        rv = $random(seed);
        @(posedge core_clk);
        flag_direction <= 13'h1fff;
        ext_level <= rv[12:0];
        repeat (12) @(posedge core_clk);
        note(1, {r[15:13], rv[12:0] ^ p}, 0);
        note(3, 16'h0000, 0);
        $display("test input flags done");
        // unrouted pins: bus follows internal flags, starts take their pin level with polarity from the register
        @(posedge core_clk);
        flag_source <= 13'h0000;
        repeat (12) @(posedge core_clk);
        note(1, r, 0);
        note(3, 16'h0200, 0);
        note(5, {10'h000, rv[8:3] ^ p[8:3]}, 0);
        $display("test unrouted flags done");
        for (int i = 0; i < 14; i++) begin
            rv = $random(seed);
            x = (i < 13) ? (13'h0001 << i) : (rv[12:0] | 13'h0001);
            @(posedge core_clk);
            irq_src <= x;
            note(4, 16'h0000, 1);
            note(2, 16'h0000, 1);
            rd(10'h1d4, {3'h0, x});
            @(posedge core_clk);
            irq_src <= x | (13'h0001 << ((i + 5) % 13));
            rd(10'h1d4, {3'h0, x});
            @(posedge core_clk);
            irq_src <= 13'h0000;
            note(4, 16'h0001, 1);
            note(2, 16'h0200, 1);
            rd(10'h1d4, 16'h0000);
        end
        $display("test interrupt sources done");
        // reset in the middle of a held interrupt must release the pin and zero both registers
        @(posedge core_clk);
        irq_src <= 13'h0001;
        repeat (3) @(posedge core_clk);
        rstn <= 1'b0;
        irq_src <= 13'h0000;
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        note(4, 16'h0001, 0);
        rd(10'h1c2, 16'h0000);
        rd(10'h1d4, 16'h0000);
        $display("test mid-run reset done");
        for (int k = 0; k < 50 && notes.size() > 0; k++) begin
            @(posedge core_clk);
        end
        if (notes.size() > 0) begin
            miscompares++;
        end
        give_verdict();
    end
endmodule
`default_nettype wire
